// ---- rtl/irtc_pkg.sv ----
// constants, register map and state layout of the timecode controller
// Behaviour
// - selecting level-shift input disables the AM input; clearing it with the slave enabled restores it, reset leaves it off
// - one chosen external pin is the level-shift input, termination per pin
// - offset tolerance flag uses 1 us for level-shift and 10 us for AM
// - each recovered second, capture clock-minus-PPS difference in nanoseconds
// - master enabled sends the clock time as a timecode frame every second
// - master disabled stops the timecode output at once
// - master status reads 1 while frames are sent, 0 otherwise
// - master reset clears every master setting, output type and pin included
// - control-bits register is read/write, low 18 bits, sent in the frame
// - leap hour readable back; extra second sent after 59:59 of that hour
// - slave enabled with valid input produces a PPS pulse
// - slave disable stops PPS, resets decoder, clears input type and pin
// - slave takes exactly one input, AM or one level-shift pin
package irtc_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          UNIT_NS       = 1000000;
    localparam int          UNIT_CYC_DEF  = UNIT_NS / CLK_PERIOD_NS;
    localparam int          UNIT_CNT_W    = 20;
    localparam int          NUM_PINS      = 12;
    localparam int          FRAME_BITS    = 100;
    localparam logic [3:0]  BIT_UNITS     = 4'hA;
    localparam logic [3:0]  ZERO_UNITS    = 4'h2;
    localparam logic [3:0]  ONE_UNITS     = 4'h5;
    localparam logic [3:0]  MARK_UNITS    = 4'h8;
    localparam logic [4:0]  ZERO_MAX      = 5'h3;
    localparam logic [4:0]  ONE_MAX       = 5'h6;
    localparam logic [4:0]  LOSS_UNITS    = 5'h14;
    localparam logic [29:0] NS_PER_SEC    = 30'h3B9ACA00;
    localparam logic [29:0] NS_HALF       = 30'h1DCD6500;
    localparam logic [31:0] TOL_DCLS_NS   = 32'h000003E8;
    localparam logic [31:0] TOL_AM_NS     = 32'h00002710;
    // frame field positions
    localparam int SEC_POS = 1;
    localparam int MIN_POS = 10;
    localparam int HR_POS  = 20;
    localparam int DAY_POS = 30;
    localparam int YR_POS  = 50;
    localparam int CB0_POS = 60;
    localparam int CB1_POS = 70;
    localparam logic [5:0] LEAP_SEC = 6'h3C;
    localparam logic [5:0] LAST_SM  = 6'h3B;
    // register offsets
    localparam logic [7:0] MCTRL_OFF  = 8'h00;
    localparam logic [7:0] CBITS_OFF  = 8'h04;
    localparam logic [7:0] LEAP_OFF   = 8'h08;
    localparam logic [7:0] SCTRL_OFF  = 8'h0C;
    localparam logic [7:0] SOFFS_OFF  = 8'h10;
    // control fields
    localparam int M_EN_BIT = 0;
    localparam int M_RST_BIT = 1;
    localparam int M_TYPE_LSB = 2;
    localparam int PIN_LSB = 4;
    localparam int M_BUSY_BIT = 8;
    localparam int S_EN_BIT = 0;
    localparam int S_DCLS_BIT = 1;
    localparam int S_TERM_BIT = 8;
    localparam int S_VALID_BIT = 16;
    localparam int S_TOL_BIT = 17;
    localparam int LEAP_DAY_LSB = 7;
    localparam int LEAP_HR_LSB = 16;
    localparam int LEAP_ARM_BIT = 31;
    localparam logic [1:0] TYPE_AM = 2'h1;
    localparam logic [1:0] TYPE_DCLS = 2'h2;

    typedef struct packed {
        logic                  m_en;
        logic [1:0]            m_type;
        logic [3:0]            m_pin;
        logic [17:0]           cbits;
        logic [6:0]            leap_year;
        logic [8:0]            leap_day;
        logic [4:0]            leap_hour;
        logic                  leap_arm;
        logic                  leap_hold;
        logic                  m_run;
        logic [UNIT_CNT_W-1:0] m_div;
        logic [3:0]            m_unit;
        logic [6:0]            m_bit;
        logic [99:0]           frame;
        logic                  m_lvl;
        logic                  s_en;
        logic                  s_dcls;
        logic [3:0]            s_pin;
        logic                  s_term;
        logic                  s_prev;
        logic [UNIT_CNT_W-1:0] s_div;
        logic [4:0]            s_units;
        logic [4:0]            s_idle;
        logic                  s_last_mk;
        logic                  s_valid;
        logic                  s_pps;
        logic [29:0]           edge_ns;
        logic [31:0]           offs;
        logic [31:0]           rdata;
    } irtc_state_s;
endpackage : irtc_pkg

// ---- rtl/irtc_ctrl.sv ----
// timecode master encoder, slave decoder and register file
module irtc_ctrl #(
    parameter logic [irtc_pkg::UNIT_CNT_W-1:0] UNIT_CYC =
        irtc_pkg::UNIT_CNT_W'(irtc_pkg::UNIT_CYC_DEF)
) (
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [31:0]                   reg_wdata,
    output logic      [31:0]                   reg_rdata,
    input  wire logic                          posix_pps,
    input  wire logic [29:0]                   posix_ns,
    input  wire logic [5:0]                    tod_sec,
    input  wire logic [5:0]                    tod_min,
    input  wire logic [4:0]                    tod_hour,
    input  wire logic [8:0]                    tod_yday,
    input  wire logic [6:0]                    tod_year,
    output logic                               tc_am_high,
    output logic                               tc_am_out_en,
    output logic                               master_busy,
    input  wire logic                          am_env_in,
    output logic                               am_in_en,
    input  wire logic [irtc_pkg::NUM_PINS-1:0] ext_gp_pin_n_in,
    output logic      [irtc_pkg::NUM_PINS-1:0] ext_gp_pin_n_out,
    output logic      [irtc_pkg::NUM_PINS-1:0] ext_gp_pin_n_oe,
    output logic      [irtc_pkg::NUM_PINS-1:0] ext_gp_pin_n_term,
    output logic                               irig_pps,
    output logic                               sync_in_tol
);
    import irtc_pkg::*;

    irtc_state_s r;
    irtc_state_s next_r;

    function automatic logic [11:0] to_bcd(input logic [8:0] v);
        logic [8:0] h;
        logic [8:0] t;
        h = v / 9'd100;
        t = (v - h * 9'd100) / 9'd10;
        return {h[3:0], t[3:0], 4'(v - h * 9'd100 - t * 9'd10)};
    endfunction : to_bcd

    function automatic logic [99:0] build_frame(input logic [5:0] s,
        input logic [5:0] m, input logic [4:0] h, input logic [8:0] d,
        input logic [6:0] y, input logic [17:0] cb);
        logic [99:0] f;
        logic [11:0] b;
        f = '0;
        b = to_bcd({3'h0, s});
        f[SEC_POS+:4] = b[3:0];
        f[SEC_POS+5+:3] = b[6:4];
        b = to_bcd({3'h0, m});
        f[MIN_POS+:4] = b[3:0];
        f[MIN_POS+5+:3] = b[6:4];
        b = to_bcd({4'h0, h});
        f[HR_POS+:4] = b[3:0];
        f[HR_POS+5+:2] = b[5:4];
        b = to_bcd(d);
        f[DAY_POS+:4] = b[3:0];
        f[DAY_POS+5+:4] = b[7:4];
        f[DAY_POS+10+:2] = b[9:8];
        b = to_bcd({2'h0, y});
        f[YR_POS+:4] = b[3:0];
        f[YR_POS+5+:4] = b[7:4];
        f[CB0_POS+:9] = cb[8:0];
        f[CB1_POS+:9] = cb[17:9];
        return f;
    endfunction : build_frame

    function automatic logic [3:0] sym_units(input logic [6:0] idx,
        input logic [99:0] f);
        if (idx == 7'h0 || idx % 7'd10 == 7'd9) begin
            return MARK_UNITS;
        end
        return f[idx] ? ONE_UNITS : ZERO_UNITS;
    endfunction : sym_units

    function automatic logic [31:0] abs32(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction : abs32

    logic        wr_mctrl;
    logic        wr_sctrl;
    logic        src;
    logic        frame_end;
    logic [31:0] diff;
    logic [31:0] tol;

    always_comb begin
        next_r = r;
        wr_mctrl = reg_wr && reg_addr == MCTRL_OFF;
        wr_sctrl = reg_wr && reg_addr == SCTRL_OFF;
        frame_end = 1'b0;
        src = r.s_dcls ? (r.s_pin < 4'(NUM_PINS) ?
              ext_gp_pin_n_in[r.s_pin] : 1'b0) : am_env_in;
        diff = r.edge_ns >= NS_HALF ?
               32'(r.edge_ns) - 32'(NS_PER_SEC) : 32'(r.edge_ns);
        if (r.m_en && posix_pps) begin
            next_r.m_run = 1'b1;
            next_r.m_div = '0;
            next_r.m_unit = '0;
            next_r.m_bit = '0;
            if (r.leap_hold) begin
                next_r.frame = r.frame;
                next_r.frame[SEC_POS+:4] = 4'h0;
                next_r.frame[SEC_POS+5+:3] = 3'h6;
                next_r.leap_hold = 1'b0;
                next_r.leap_arm = 1'b0;
            end else begin
                next_r.frame = build_frame(tod_sec, tod_min, tod_hour,
                                           tod_yday, tod_year, r.cbits);
                next_r.leap_hold = r.leap_arm && tod_sec == LAST_SM &&
                    tod_min == LAST_SM && tod_hour == r.leap_hour &&
                    tod_yday == r.leap_day && tod_year == r.leap_year;
            end
        end else if (r.m_run) begin
            next_r.m_div = r.m_div + 1'b1;
            if (r.m_div == UNIT_CYC - 1'b1) begin
                next_r.m_div = '0;
                next_r.m_unit = r.m_unit + 1'b1;
                if (r.m_unit == BIT_UNITS - 1'b1) begin
                    next_r.m_unit = '0;
                    next_r.m_bit = r.m_bit + 1'b1;
                    frame_end = r.m_bit == 7'(FRAME_BITS - 1);
                end
            end
        end
        if (frame_end) begin
            next_r.m_run = 1'b0;
        end
        next_r.m_lvl = r.m_run && r.m_unit < sym_units(r.m_bit, r.frame);
        // slave decoder
        next_r.s_pps = 1'b0;
        next_r.s_prev = src;
        if (r.s_en) begin
            next_r.s_div = r.s_div + 1'b1;
            if (r.s_div == UNIT_CYC - 1'b1) begin
                next_r.s_div = '0;
                if (src && r.s_units != '1) begin
                    next_r.s_units = r.s_units + 1'b1;
                end
                if (r.s_idle == LOSS_UNITS) begin
                    next_r.s_valid = 1'b0;
                    next_r.s_last_mk = 1'b0;
                end else begin
                    next_r.s_idle = r.s_idle + 1'b1;
                end
            end
            if (src && !r.s_prev) begin
                next_r.s_div = '0;
                next_r.s_units = '0;
                next_r.s_idle = '0;
                next_r.edge_ns = posix_ns;
            end
            if (!src && r.s_prev) begin
                next_r.s_last_mk = r.s_units > ONE_MAX;
                if (r.s_units > ONE_MAX && r.s_last_mk) begin
                    next_r.s_valid = 1'b1;
                    next_r.s_pps = 1'b1;
                    next_r.offs = diff;
                end
            end
        end
        // register writes
        if (wr_mctrl) begin
            if (reg_wdata[M_RST_BIT]) begin
                next_r.m_en = 1'b0;
                next_r.m_type = '0;
                next_r.m_pin = '0;
                next_r.cbits = '0;
                next_r.leap_year = '0;
                next_r.leap_day = '0;
                next_r.leap_hour = '0;
                next_r.leap_arm = 1'b0;
                next_r.leap_hold = 1'b0;
            end else begin
                next_r.m_en = reg_wdata[M_EN_BIT];
                next_r.m_type = reg_wdata[M_TYPE_LSB+:2];
                next_r.m_pin = reg_wdata[PIN_LSB+:4];
            end
        end
        if (wr_mctrl && !next_r.m_en) begin
            next_r.m_run = 1'b0;
            next_r.m_lvl = 1'b0;
        end
        if (reg_wr && reg_addr == CBITS_OFF) begin
            next_r.cbits = reg_wdata[17:0];
        end
        if (reg_wr && reg_addr == LEAP_OFF) begin
            next_r.leap_year = reg_wdata[6:0];
            next_r.leap_day = reg_wdata[LEAP_DAY_LSB+:9];
            next_r.leap_hour = reg_wdata[LEAP_HR_LSB+:5];
            next_r.leap_arm = reg_wdata[LEAP_ARM_BIT];
        end
        if (wr_sctrl) begin
            next_r.s_en = reg_wdata[S_EN_BIT];
            next_r.s_dcls = reg_wdata[S_DCLS_BIT];
            next_r.s_pin = reg_wdata[PIN_LSB+:4];
            next_r.s_term = reg_wdata[S_TERM_BIT];
            if (!reg_wdata[S_EN_BIT]) begin
                next_r.s_dcls = 1'b0;
                next_r.s_pin = '0;
                next_r.s_term = 1'b0;
                next_r.s_valid = 1'b0;
                next_r.s_last_mk = 1'b0;
                next_r.s_pps = 1'b0;
                next_r.s_div = '0;
                next_r.s_units = '0;
                next_r.s_idle = '0;
            end
        end
        next_r.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                MCTRL_OFF: next_r.rdata = 32'({r.m_run, r.m_pin,
                                               r.m_type, 1'b0, r.m_en});
                CBITS_OFF: next_r.rdata = 32'(r.cbits);
                LEAP_OFF:  next_r.rdata = {r.leap_arm, 10'h0, r.leap_hour,
                                           r.leap_day, r.leap_year};
                SCTRL_OFF: next_r.rdata = 32'({sync_in_tol, r.s_valid,
                    7'h0, r.s_term, r.s_pin, 2'h0, r.s_dcls, r.s_en});
                SOFFS_OFF: next_r.rdata = r.offs;
                default:   next_r.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign master_busy = r.m_run;
    assign reg_rdata = r.rdata;
    assign tc_am_high = r.m_lvl;
    assign tc_am_out_en = r.m_run && r.m_type[0];
    assign am_in_en = r.s_en && !r.s_dcls;
    assign ext_gp_pin_n_out = {NUM_PINS{r.m_lvl}};
    assign ext_gp_pin_n_oe = (r.m_run && r.m_type[1]) ?
        NUM_PINS'(1) << r.m_pin : '0;
    assign ext_gp_pin_n_term = (r.s_en && r.s_dcls && r.s_term) ?
        NUM_PINS'(1) << r.s_pin : '0;
    assign irig_pps = r.s_pps;
    assign tol = r.s_dcls ? TOL_DCLS_NS : TOL_AM_NS;
    assign sync_in_tol = r.s_valid && abs32(r.offs) <= tol;

    a_am_gated: assert property (@(posedge sys_clk)
        disable iff (!resetn) r.s_dcls |-> !am_in_en)
        else $error("am input on with dcls");
    a_frame_start: assert property (@(posedge sys_clk)
        disable iff (!resetn) $rose(r.m_run) |-> $past(posix_pps && r.m_en))
        else $error("frame started without pps");
    a_master_stop: assert property (@(posedge sys_clk)
        disable iff (!resetn) (wr_mctrl && !reg_wdata[M_EN_BIT]) |=>
        !master_busy && !tc_am_high) else $error("master kept sending");
    a_master_reset: assert property (@(posedge sys_clk)
        disable iff (!resetn) (wr_mctrl && reg_wdata[M_RST_BIT]) |=>
        r.m_type == 2'h0 && r.m_pin == 4'h0 && r.cbits == 18'h0 && !r.m_en)
        else $error("master reset left settings");
    a_cbits_store: assert property (@(posedge sys_clk)
        disable iff (!resetn) (reg_wr && reg_addr == CBITS_OFF) ##1
        (reg_rd && reg_addr == CBITS_OFF) |=>
        reg_rdata == 32'($past(reg_wdata[17:0], 2)))
        else $error("control bits readback wrong");
    a_leap_sixty: assert property (@(posedge sys_clk)
        disable iff (!resetn) (r.leap_hold && r.m_en && posix_pps) |=>
        r.frame[SEC_POS+5+:3] == 3'h6 && r.frame[SEC_POS+:4] == 4'h0)
        else $error("leap second not sent as 60");
    a_pps_valid: assert property (@(posedge sys_clk)
        disable iff (!resetn) irig_pps |-> r.s_en && r.s_valid &&
        $past(r.s_prev) && !$past(src)) else $error("pps without valid input");
    a_slave_clear: assert property (@(posedge sys_clk)
        disable iff (!resetn) (wr_sctrl && !reg_wdata[S_EN_BIT]) |=>
        !r.s_dcls && r.s_pin == 4'h0 && !r.s_valid ##1 !irig_pps)
        else $error("slave disable left state");
    a_offs_update: assert property (@(posedge sys_clk)
        disable iff (!resetn) $changed(r.offs) |-> irig_pps)
        else $error("offset changed outside pps");
endmodule : irtc_ctrl

// ---- verification/irtc_far_end.sv ----
// far-end timecode source feeding the slave input line
module irtc_far_end #(
    parameter int UNIT_CYC = 4
) (
    input  wire logic sys_clk,
    input  wire logic run,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b0;
    always begin : gen
        int b;
        int u;
        int hi;
        @(posedge sys_clk);
        for (b = 0; b < 100 && run; b++) begin
            hi = (b == 0 || b % 10 == 9) ? 8 : 2;
            for (u = 0; u < 10; u++) begin
                line <= (u < hi);
                repeat (UNIT_CYC) @(posedge sys_clk);
            end
        end
        // absent envelope idles low
        line <= 1'b0;
    end
endmodule : irtc_far_end

// ---- verification/irtc_ctrl_tb.sv ----
// self-checking bench for the timecode controller
module irtc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import irtc_pkg::*;
    logic                sys_clk = 1'b0;
    logic                resetn = 1'b0;
    logic [7:0]          reg_addr = 8'h00;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [31:0]         reg_wdata = 32'h0;
    logic [31:0]         reg_rdata;
    logic                posix_pps = 1'b0;
    logic [29:0]         posix_ns = 30'h0;
    logic [5:0]          tod_sec = 6'h00;
    logic [5:0]          tod_min = 6'h00;
    logic [4:0]          tod_hour = 5'h00;
    logic [8:0]          tod_yday = 9'h000;
    logic [6:0]          tod_year = 7'h00;
    logic [NUM_PINS-1:0] pin_out;
    logic                am_sel = 1'b1;
    logic                tc_am_high;
    logic                tc_am_out_en;
    logic                master_busy;
    logic                am_in_en;
    logic [NUM_PINS-1:0] pin_in;
    logic [NUM_PINS-1:0] pin_oe;
    logic [NUM_PINS-1:0] pin_term;
    logic                irig_pps;
    logic                sync_in_tol;
    logic                fe_run = 1'b0;
    logic                fe_line;
    int                  error_cnt = 0;
    int                  check_count = 0;
    int                  cyc = 0;

    assign pin_in = {6'h00, fe_line & ~am_sel, 5'h00};

    irtc_ctrl #(.UNIT_CYC(20'h00004)) i_irtc_ctrl (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .posix_pps(posix_pps), .posix_ns(posix_ns),
        .tod_sec(tod_sec), .tod_min(tod_min), .tod_hour(tod_hour),
        .tod_yday(tod_yday), .tod_year(tod_year), .tc_am_high(tc_am_high),
        .tc_am_out_en(tc_am_out_en), .master_busy(master_busy),
        .am_env_in(fe_line & am_sel), .am_in_en(am_in_en),
        .ext_gp_pin_n_in(pin_in),
        .ext_gp_pin_n_out(pin_out), .ext_gp_pin_n_oe(pin_oe),
        .ext_gp_pin_n_term(pin_term), .irig_pps(irig_pps),
        .sync_in_tol(sync_in_tol)
    );

    irtc_far_end #(.UNIT_CYC(4)) i_irtc_far_end (
        .sys_clk(sys_clk), .run(fe_run), .line(fe_line)
    );

    always #5 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            $display("[FAIL] %0t run limit reached", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
    endtask : reg_write

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
        tick(1);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, what);
    endtask : rchk

    task automatic wr_rchk(input logic [7:0] a, input logic [31:0] d,
                           input logic [31:0] exp, input string what);
        tick(1);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        chk(reg_rdata, exp, what);
    endtask : wr_rchk

    task automatic bit1_width(output int n);
        tick(41);
        n = 0;
        while (pin_out[0] === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
    endtask : bit1_width

    task automatic pps_pulse();
        tick(1);
        posix_pps = 1'b1;
        tick(1);
        posix_pps = 1'b0;
    endtask : pps_pulse

    task automatic t_regs();
        rchk(MCTRL_OFF, 32'h0, "master ctrl reset");
        rchk(SCTRL_OFF, 32'h0, "slave ctrl reset");
        reg_write(8'h14, 32'hFFFFFFFF);
        rchk(8'h14, 32'h0, "unmapped read");
        wr_rchk(CBITS_OFF, 32'hFFFFFFFF, 32'h0003FFFF,
                "control bits width");
        reg_write(LEAP_OFF, 32'h80173C8E);
        rchk(LEAP_OFF, 32'h80173C8E, "leap readback");
        $display("test regs done");
    endtask : t_regs

    task automatic t_master();
        int n;
        reg_write(MCTRL_OFF, 32'h00000035);
        pps_pulse();
        chk(master_busy, 1'b1, "busy after pps");
        tick(1);
        n = 0;
        while (tc_am_high === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk(n, 32, "first marker width");
        chk(tc_am_out_en, 1'b1, "am output on");
        rchk(MCTRL_OFF, 32'h00000135, "status sending");
        reg_write(MCTRL_OFF, 32'h00000039);
        chk(pin_oe, 12'h008, "level-shift pin drive");
        reg_write(MCTRL_OFF, 32'h00000038);
        tick(1);
        chk(master_busy, 1'b0, "busy after disable");
        chk(pin_oe, 12'h000, "pin released");
        pps_pulse();
        tick(1);
        chk(master_busy, 1'b0, "pps while disabled");
        rchk(MCTRL_OFF, 32'h00000038, "status idle");
        $display("test master done");
    endtask : t_master

    task automatic t_mreset();
        reg_write(CBITS_OFF, 32'h0002AAAA);
        reg_write(MCTRL_OFF, 32'h00000002);
        rchk(MCTRL_OFF, 32'h0, "type and pin cleared");
        rchk(CBITS_OFF, 32'h0, "control bits cleared");
        rchk(LEAP_OFF, 32'h0, "leap cleared");
        $display("test master reset done");
    endtask : t_mreset

    task automatic t_leap();
        int n;
        reg_write(LEAP_OFF, 32'h80175A19);
        tod_sec = 6'h3B;
        tod_min = 6'h3B;
        tod_hour = 5'h17;
        tod_yday = 9'h0B4;
        tod_year = 7'h19;
        reg_write(MCTRL_OFF, 32'h00000009);
        pps_pulse();
        chk(pin_oe, 12'h001, "level-shift pin 0 drive");
        chk(tc_am_out_en, 1'b0, "am output off for dcls");
        bit1_width(n);
        chk(n, 20, "seconds units bit at 59");
        pps_pulse();
        bit1_width(n);
        chk(n, 8, "seconds units bit at 60");
        pps_pulse();
        bit1_width(n);
        chk(n, 20, "one leap second only");
        reg_write(MCTRL_OFF, 32'h00000000);
        $display("test leap done");
    endtask : t_leap

    task automatic t_slave(input logic dcls, input logic [29:0] ns,
                           input logic tol);
        logic [31:0] w;
        int          n;
        w = dcls ? 32'h00000153 : 32'h00000001;
        am_sel = !dcls;
        reg_write(SCTRL_OFF, w);
        posix_ns = ns;
        chk(am_in_en, !dcls, "am input select");
        chk(pin_term, dcls ? 12'h020 : 12'h000, "termination");
        fe_run = 1'b1;
        n = 0;
        while (irig_pps !== 1'b1 && n < 9000) begin
            tick(1);
            n++;
        end
        chk(irig_pps, 1'b1, "pps recovered");
        rchk(SOFFS_OFF, {2'b00, ns}, "offset ns");
        chk(sync_in_tol, tol, "tolerance flag");
        rchk(SCTRL_OFF, w | {14'h0, tol, 1'b1, 16'h0}, "slave status");
        if (dcls) begin
            reg_write(SCTRL_OFF, 32'h00000001);
            chk(am_in_en, 1'b1, "am input restored");
        end
        reg_write(SCTRL_OFF, 32'h00000000);
        chk(am_in_en, 1'b0, "am input off");
        n = 0;
        repeat (4100) begin
            tick(1);
            if (irig_pps !== 1'b0)
                n++;
        end
        chk(n, 0, "no pps when disabled");
        rchk(SCTRL_OFF, 32'h0, "slave cleared");
        fe_run = 1'b0;
        tick(50);
        $display("test slave done");
    endtask : t_slave

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        t_regs();
        t_master();
        t_mreset();
        t_leap();
        t_slave(1'b1, 30'd1000, 1'b1);
        t_slave(1'b1, 30'd1001, 1'b0);
        t_slave(1'b0, 30'd10000, 1'b1);
        end_sim();
    end
endmodule : irtc_ctrl_tb
